// *** pkg/acd_cfg.svh ***
// register offsets, field positions and reset values of the action block
`ifndef ACD_CFG_SVH
`define ACD_CFG_SVH

// register byte offsets (word aligned)
`define ACD_OFF_AUTH_KEY    8'h00
`define ACD_OFF_TEAM_KEY    8'h04
`define ACD_OFF_SUBTEAM     8'h08
`define ACD_OFF_ENTRY_IDX   8'h0c
`define ACD_OFF_TRIG_CTRL   8'h10
`define ACD_OFF_SRC_CTRL    8'h14
`define ACD_OFF_STATUS      8'h18
`define ACD_OFF_FRAME_CNT   8'h1c
`define ACD_OFF_PSET        8'h20

// trigger control fields
`define ACD_TRIG_SEL_LSB    0
`define ACD_TRIG_ON_BIT     4
`define ACD_TRIG_SRC_BIT    8
// source control fields
`define ACD_CLR_SRC_BIT     0
`define ACD_STEP_SRC_BIT    1

// reset values
`define ACD_RST_KEY         32'h0000_0000
`define ACD_RST_ENTRY       32'h0000_0001
`define ACD_NUM_ACTIONS     32'h0000_0001

`endif

// *** pkg/acd_pkg.sv ***
// types shared by the action command dispatch block
`default_nettype none
package acd_pkg;
	// selectable trigger targets
	typedef enum logic [1:0] {
		ACD_TGT_FRAME,
		ACD_TGT_CAPTURE,
		ACD_TGT_ROW
	} acd_target_t;

	// one incoming broadcast action message
	typedef struct packed {
		logic [31:0] auth_key;
		logic [31:0] team_key;
		logic [31:0] subteam_mask;
	} acd_msg_t;

	// stored match configuration
	typedef struct packed {
		logic [31:0] auth_key;
		logic [31:0] team_key;
		logic [31:0] subteam_mask;
	} acd_keys_t;
endpackage
`default_nettype wire

// *** rtl/acd_match.sv ***
// key and mask comparator producing a one-cycle action pulse
`default_nettype none
module acd_match
	import acd_pkg::*;
#(
	parameter int KEY_W = 32
) (
	// clock and reset
	input  wire logic      clk_i,
	input  wire logic      rst_i,
	// message and stored keys
	input  wire logic      msg_valid_i,
	input  wire acd_msg_t  msg_i,
	input  wire acd_keys_t keys_i,
	// result
	output logic           hit_o,
	output logic           miss_o
);
	// elaboration guard: the message carries fixed 32-bit keys
	if (KEY_W != 32) begin : g_bad_key_w
		$error("acd_match: key width must be 32");
	end

	logic dev_ok;   // device key equal
	logic team_ok;  // group key equal
	logic mask_ok;  // common mask bit present

	// full 32-bit equality, no partial compare
	assign dev_ok  = (msg_i.auth_key == keys_i.auth_key);
	assign team_ok = (msg_i.team_key == keys_i.team_key);
	// zero mask on either side never matches; all-ones hits any non-zero
	assign mask_ok = |(msg_i.subteam_mask & keys_i.subteam_mask);

	// registered verdict, exactly one cycle per message
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hit_o  <= 1'b0;
			miss_o <= 1'b0;
		end else begin
			hit_o  <= msg_valid_i & dev_ok & team_ok & mask_ok;
			miss_o <= msg_valid_i & ~(dev_ok & team_ok & mask_ok);
		end
	end
endmodule // acd_match
`default_nettype wire

// *** rtl/acd_dispatch.sv ***
// action command dispatch: key match, trigger, counter and sequence control
//
// Summary of operation
// - act only when device and group keys equal
// - mask match needs non-zero bitwise AND
// - action drives frame, capture or row trigger
// - trigger fires only while triggering switched on
// - exactly one action source offered everywhere
// - action clears frame counter when selected
// - action steps parameter set when selected
// - all-ones message mask hits any non-zero mask
// - device key is 32-bit, write only
// - group key and mask are 32-bit each
`include "acd_cfg.svh"
`default_nettype none
module acd_dispatch
	import acd_pkg::*;
#(
	parameter int FCNT_W = 32,   // frame counter width
	parameter int PSET_W = 3     // parameter set index width
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// incoming broadcast action message
	input  wire logic        msg_valid_i,
	input  wire acd_msg_t    msg_i,
	// camera events
	input  wire logic        frame_done_i,
	// trigger outputs
	output logic             frame_begin_trigger_o,
	output logic             capture_run_begin_trigger_o,
	output logic             row_begin_trigger_o,
	// counter and sequence
	output logic [FCNT_W-1:0] frame_count_o,
	output logic [PSET_W-1:0] param_set_o,
	output logic             action_pulse_o
);
	// elaboration guards: counter must fit the 32-bit read word
	if (FCNT_W < 1 || FCNT_W > 32) begin : g_bad_fcnt_w
		$error("acd_dispatch: bad FCNT_W");
	end
	// the set index shares its read word with the action count byte
	if (PSET_W < 1 || PSET_W > 8) begin : g_bad_pset_w
		$error("acd_dispatch: bad PSET_W");
	end

	// stored configuration
	acd_keys_t   keys_q;               // device key, group key, mask
	logic [31:0] entry_idx_q;          // action entry index
	logic [1:0]  trig_target_choice_q; // selected trigger target
	logic        trig_on_off_q;        // triggered operation enabled
	logic        trig_from_action_q;   // trigger sourced from action
	logic        frame_count_clear_src_q; // counter clear from action
	logic        param_set_step_src_q; // sequence step from action
	// status
	logic [15:0] hit_cnt_q;            // matched messages seen
	logic [15:0] miss_cnt_q;           // rejected messages seen
	logic [FCNT_W-1:0] frame_cnt_q;    // frame counter
	logic [PSET_W-1:0] pset_q;         // current parameter set

	logic hit;                          // one-cycle action signal
	logic miss;                         // rejected message
	logic wr_en;                        // bus write strobe
	logic [31:0] rd_d;                  // read data mux

	// the single comparator: only one action signal exists
	acd_match #(
		.KEY_W (32)
	) u_match (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.msg_valid_i (msg_valid_i),
		.msg_i       (msg_i),
		.keys_i      (keys_q),
		.hit_o       (hit),
		.miss_o      (miss)
	);

	// write only while not already acknowledging, so one write per cycle
	assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;

	// byte-lane merge for 32-bit registers
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction

	// key registers, all full 32-bit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			keys_q <= {`ACD_RST_KEY, `ACD_RST_KEY, `ACD_RST_KEY};
		end else if (wr_en) begin
			case (wb_adr_i)
				`ACD_OFF_AUTH_KEY: begin
					keys_q.auth_key <= merge(keys_q.auth_key, wb_dat_i,
						wb_sel_i);
				end
				`ACD_OFF_TEAM_KEY: begin
					keys_q.team_key <= merge(keys_q.team_key, wb_dat_i,
						wb_sel_i);
				end
				`ACD_OFF_SUBTEAM: begin
					keys_q.subteam_mask <= merge(keys_q.subteam_mask,
						wb_dat_i, wb_sel_i);
				end
				default: begin
				end
			endcase
		end
	end

	// entry index is stored as written; only entry 1 is meaningful
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			entry_idx_q <= `ACD_RST_ENTRY;
		end else if (wr_en && wb_adr_i == `ACD_OFF_ENTRY_IDX) begin
			entry_idx_q <= merge(entry_idx_q, wb_dat_i, wb_sel_i);
		end
	end

	// trigger and source control
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trig_target_choice_q    <= 2'h0;
			trig_on_off_q           <= 1'b0;
			trig_from_action_q      <= 1'b0;
			frame_count_clear_src_q <= 1'b0;
			param_set_step_src_q    <= 1'b0;
		end else if (wr_en) begin
			if (wb_adr_i == `ACD_OFF_TRIG_CTRL && wb_sel_i[0]) begin
				// code 3 is no target; keep previous choice
				if (wb_dat_i[`ACD_TRIG_SEL_LSB +: 2] != 2'h3) begin
					trig_target_choice_q <=
						wb_dat_i[`ACD_TRIG_SEL_LSB +: 2];
				end
			end
			if (wb_adr_i == `ACD_OFF_TRIG_CTRL && wb_sel_i[0]) begin
				trig_on_off_q <= wb_dat_i[`ACD_TRIG_ON_BIT];
			end
			if (wb_adr_i == `ACD_OFF_TRIG_CTRL && wb_sel_i[1]) begin
				trig_from_action_q <= wb_dat_i[`ACD_TRIG_SRC_BIT];
			end
			if (wb_adr_i == `ACD_OFF_SRC_CTRL && wb_sel_i[0]) begin
				frame_count_clear_src_q <= wb_dat_i[`ACD_CLR_SRC_BIT];
				param_set_step_src_q    <= wb_dat_i[`ACD_STEP_SRC_BIT];
			end
		end
	end

	// trigger outputs: one-cycle pulse on the selected target
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_begin_trigger_o       <= 1'b0;
			capture_run_begin_trigger_o <= 1'b0;
			row_begin_trigger_o         <= 1'b0;
		end else begin
			frame_begin_trigger_o <= hit & trig_on_off_q & trig_from_action_q
				& (trig_target_choice_q == ACD_TGT_FRAME);
			capture_run_begin_trigger_o <= hit & trig_on_off_q
				& trig_from_action_q
				& (trig_target_choice_q == ACD_TGT_CAPTURE);
			row_begin_trigger_o <= hit & trig_on_off_q & trig_from_action_q
				& (trig_target_choice_q == ACD_TGT_ROW);
		end
	end

	// frame counter: a clearing action wins over a finishing frame
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_cnt_q <= '0;
		end else if (hit && frame_count_clear_src_q) begin
			frame_cnt_q <= '0;
		end else if (frame_done_i) begin
			frame_cnt_q <= frame_cnt_q + 1'b1;
		end
	end

	// parameter set: wraps after the last index
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pset_q <= '0;
		end else if (hit && param_set_step_src_q) begin
			pset_q <= pset_q + 1'b1;
		end
	end

	// match statistics, saturating so software sees activity
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hit_cnt_q  <= 16'h0000;
			miss_cnt_q <= 16'h0000;
		end else begin
			if (hit && hit_cnt_q != 16'hffff) begin
				hit_cnt_q <= hit_cnt_q + 16'h0001;
			end
			if (miss && miss_cnt_q != 16'hffff) begin
				miss_cnt_q <= miss_cnt_q + 16'h0001;
			end
		end
	end

	// mirrored outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_count_o  <= '0;
			param_set_o    <= '0;
			action_pulse_o <= 1'b0;
		end else begin
			frame_count_o  <= (hit && frame_count_clear_src_q) ? '0
				: frame_cnt_q;
			param_set_o    <= pset_q;
			action_pulse_o <= hit;
		end
	end

	// read mux; the device key always reads zero
	always_comb begin
		rd_d = 32'h0000_0000;
		case (wb_adr_i)
			`ACD_OFF_AUTH_KEY:  rd_d = 32'h0000_0000;
			`ACD_OFF_TEAM_KEY:  rd_d = keys_q.team_key;
			`ACD_OFF_SUBTEAM:   rd_d = keys_q.subteam_mask;
			`ACD_OFF_ENTRY_IDX: rd_d = entry_idx_q;
			`ACD_OFF_TRIG_CTRL: begin
				rd_d[`ACD_TRIG_SEL_LSB +: 2] = trig_target_choice_q;
				rd_d[`ACD_TRIG_ON_BIT]       = trig_on_off_q;
				rd_d[`ACD_TRIG_SRC_BIT]      = trig_from_action_q;
			end
			`ACD_OFF_SRC_CTRL: begin
				rd_d[`ACD_CLR_SRC_BIT]  = frame_count_clear_src_q;
				rd_d[`ACD_STEP_SRC_BIT] = param_set_step_src_q;
			end
			`ACD_OFF_STATUS:    rd_d = {miss_cnt_q, hit_cnt_q};
			`ACD_OFF_FRAME_CNT: rd_d[FCNT_W-1:0] = frame_cnt_q;
			`ACD_OFF_PSET: begin
				rd_d[PSET_W-1:0] = pset_q;
				rd_d[31:24]      = 8'(`ACD_NUM_ACTIONS);
			end
			default:            rd_d = 32'h0000_0000;  // unmapped reads zero
		endcase
	end

	// one-wait-state ack; dropped the cycle after it was given
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			wb_dat_o <= rd_d;
		end
	end
endmodule // acd_dispatch
`default_nettype wire

// *** test/acd_host_model.sv ***
// host model that broadcasts action messages toward the block
`default_nettype none
module acd_host_model
	import acd_pkg::*;
(
	// clock and request from the bench
	input  wire logic     clk_i,
	input  wire logic     go_i,
	input  wire acd_msg_t m_i,
	// broadcast toward the device
	output logic          msg_valid_o,
	output acd_msg_t      msg_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// one message per request; idle keys invert so stale keys never match
	always @(posedge clk_i) begin
		msg_valid_o <= go_i;
		msg_o <= go_i ? m_i : ~m_i;
	end
endmodule // acd_host_model
`default_nettype wire

// *** test/acd_dispatch_sva.sv ***
// port assertions for the action dispatch block
`include "acd_cfg.svh"
`default_nettype none
module acd_dispatch_sva
	import acd_pkg::*;
#(
	parameter int FCNT_W = 32,
	parameter int PSET_W = 3
) (
	// clock and reset
	input wire logic              clk_i,
	input wire logic              rst_i,
	// register bus
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_we_i,
	input wire logic [7:0]        wb_adr_i,
	input wire logic [31:0]       wb_dat_o,
	input wire logic              wb_ack_o,
	// message
	input wire logic              msg_valid_i,
	input wire acd_msg_t          msg_i,
	// outputs
	input wire logic              frame_begin_trigger_o,
	input wire logic              capture_run_begin_trigger_o,
	input wire logic              row_begin_trigger_o,
	input wire logic [FCNT_W-1:0] frame_count_o,
	input wire logic [PSET_W-1:0] param_set_o,
	input wire logic              action_pulse_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [2:0] trig;	// all trigger targets together
	assign trig = {frame_begin_trigger_o, capture_run_begin_trigger_o,
		row_begin_trigger_o};
	a_pulse_from_msg: assert property (
		action_pulse_o |-> $past(msg_valid_i, 2))
		else $error("action pulse without message");
	a_zero_mask_miss: assert property (
		msg_valid_i && msg_i.subteam_mask == 32'h0 |-> ##2 !action_pulse_o)
		else $error("zero mask fired an action");
	a_trig_onehot: assert property ($onehot0(trig))
		else $error("more than one trigger fired");
	a_trig_needs_act: assert property (|trig |-> action_pulse_o)
		else $error("trigger without action");
	a_ack_after_req: assert property (
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i) && wb_cyc_i)
		else $error("ack without request");
	a_auth_reads_zero: assert property (
		wb_ack_o && !wb_we_i && wb_adr_i == `ACD_OFF_AUTH_KEY
		|-> wb_dat_o == 32'h0) else $error("device key readable");
	a_pset_steps_one: assert property (
		$changed(param_set_o) |-> (action_pulse_o || $past(action_pulse_o))
		&& param_set_o == PSET_W'($past(param_set_o) + 1'b1))
		else $error("parameter set moved wrongly");
	a_count_moves: assert property (
		$changed(frame_count_o) |-> frame_count_o == 0
		|| frame_count_o == $past(frame_count_o) + 1'b1)
		else $error("frame count jumped");
endmodule // acd_dispatch_sva
bind acd_dispatch acd_dispatch_sva #(.FCNT_W(FCNT_W), .PSET_W(PSET_W))
	u_sva (.*);
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for the action dispatch block
`include "acd_cfg.svh"
`default_nettype none
module tb_top import acd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, rst = 1'b1, go = 1'b0, fdone = 1'b0;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;	// bus request
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, ak, tk, s = 32'h0000_92e1;
	logic        mv, ack, act, tf, tc, tr;
	logic [31:0] fcnt, rdq[$];	// expected read data
	logic [3:0]  evq[$];	// expected {action, frame, capture, row}
	logic [1:0]  vq = 2'b00;	// message age
	logic [2:0]  pset;
	acd_msg_t    m = '0, msg;
	int          fails = 0, n_checks = 0;
	acd_host_model host (.clk_i(clk), .go_i(go), .m_i(m),
		.msg_valid_o(mv), .msg_o(msg));
	acd_dispatch #(.FCNT_W(32), .PSET_W(3)) uut (.clk_i(clk), .rst_i(rst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.msg_valid_i(mv), .msg_i(msg), .frame_done_i(fdone),
		.frame_begin_trigger_o(tf), .capture_run_begin_trigger_o(tc),
		.row_begin_trigger_o(tr), .frame_count_o(fcnt),
		.param_set_o(pset), .action_pulse_o(act));
	always #5 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	task automatic chk_rd(input logic [31:0] g, e);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_ev(input logic [3:0] g, e);
		chk_rd({28'h0, g}, {28'h0, e});
	endtask
	// classic cycle: held until ack is seen, then released for a cycle
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (ack !== 1'b1) fails++;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rdq.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic send(input acd_msg_t x, input logic [3:0] e);
		@(posedge clk);
		go <= 1'b1;
		m <= x;
		evq.push_back(e);
		@(posedge clk);
		go <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic give_verdict;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// result watcher: pulses land two edges after the message is taken
	always @(posedge clk) begin
		vq <= {vq[0], mv};
		if (vq[1]) chk_ev({act, tf, tc, tr}, evq.pop_front());
		if (ack && !we) chk_rd(rdat, rdq.pop_front());
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(`ACD_OFF_ENTRY_IDX, 32'h1);
		rd(`ACD_OFF_PSET, 32'h0100_0000);
		rd(8'h3c, 32'h0);
		ak = xs(s);
		tk = xs(ak);
		bus(1'b1, `ACD_OFF_ENTRY_IDX, 32'h1);
		bus(1'b1, `ACD_OFF_AUTH_KEY, ak);
		bus(1'b1, `ACD_OFF_TEAM_KEY, tk);
		bus(1'b1, `ACD_OFF_SUBTEAM, 32'h4);
		rd(`ACD_OFF_AUTH_KEY, 32'h0);
		rd(`ACD_OFF_TEAM_KEY, tk);
		rd(`ACD_OFF_SUBTEAM, 32'h4);
		for (int t = 0; t < 3; t++) begin
			bus(1'b1, `ACD_OFF_TRIG_CTRL, 32'h110 | t);
			send('{ak, tk, 32'hffff_ffff}, 4'(4'h8 | (4'h4 >> t)));
		end
		// target code 3 must leave the row target selected
		bus(1'b1, `ACD_OFF_TRIG_CTRL, 32'h113);
		send('{ak, tk, 32'h4}, 4'h9);
		bus(1'b1, `ACD_OFF_TRIG_CTRL, 32'h100);
		send('{ak, tk, 32'h4}, 4'h8);
		send('{ak ^ 32'h1, tk, 32'h4}, 4'h0);
		send('{ak, tk ^ 32'h8000_0000, 32'h4}, 4'h0);
		send('{ak, tk, 32'h3}, 4'h0);
		send('{ak, tk, 32'h0}, 4'h0);
		bus(1'b1, `ACD_OFF_SRC_CTRL, 32'h3);
		repeat (3) begin
			@(posedge clk) fdone <= 1'b1;
			@(posedge clk) fdone <= 1'b0;
		end
		rd(`ACD_OFF_FRAME_CNT, 32'h3);
		chk_rd(fcnt, 32'h3);
		send('{ak, tk, 32'h4}, 4'h8);
		send('{ak, tk, tk | 32'h4}, 4'h8);
		rd(`ACD_OFF_FRAME_CNT, 32'h0);
		rd(`ACD_OFF_PSET, 32'h0100_0002);
		chk_rd(fcnt, 32'h0);
		chk_rd({29'h0, pset}, 32'h2);
		rd(`ACD_OFF_STATUS, 32'h0004_0007);
		repeat (3) @(posedge clk);
		give_verdict;
	end
	// watchdog well beyond the hundred-odd cycles the sequence needs
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		give_verdict;
	end
endmodule // tb_top
`default_nettype wire
